// ===== pstep_ctrl.sv
/*
 * Pitch step controller: debounces the pitch inputs, keeps the pitch step
 * in direct-select or stepping mode and paces the DA sampling strobe.
 * Assumes the pitch inputs come asynchronously from switches or another
 * controller, and that an AXI4-Lite master on CLK reaches the registers.
 */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
module pstep_ctrl #(
    parameter int DEBOUNCE_TICKS = pstep_pkg::DEBOUNCE_TICKS
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Pitch control pins.
    input wire logic [3:0] STEP_SEL,
    input wire logic PITCH_RAISE_PULSE,
    input wire logic PITCH_LOWER_PULSE,
    input wire logic PITCH_CENTER_PULSE,
    // Converter side.
    output logic [4:0] PITCH_STEP,
    output logic DA_SAMPLE_STROBE,
    // AXI4-Lite write address channel.
    input wire logic [pstep_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data channel.
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response channel.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address channel.
    input wire logic [pstep_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data channel.
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    localparam int NI = pstep_pkg::NUM_INPUTS;
    localparam logic [pstep_pkg::DEBOUNCE_W-1:0] DEB_LAST =
        pstep_pkg::DEBOUNCE_W'(DEBOUNCE_TICKS - 1);
    localparam logic [pstep_pkg::TICK_DIV_W-1:0] DIV_LAST =
        pstep_pkg::TICK_DIV_W'(pstep_pkg::TICK_DIV - 1);

    // Master tick divider.
    logic [pstep_pkg::TICK_DIV_W-1:0] div_q;
    logic tick_q;

    // Input synchronisers and chatter filters.
    logic [NI-1:0] sync1_q;
    logic [NI-1:0] sync2_q;
    logic [NI-1:0] clean_q;
    logic [NI-1:0] clean_prev_q;
    logic [pstep_pkg::DEBOUNCE_W-1:0] deb_cnt_q [NI];

    // Step state and sampling pacing.
    logic [4:0] step_q;
    logic [4:0] step_d;
    logic [pstep_pkg::PERIOD_W-1:0] per_cnt_q;
    logic strobe_q;

    // Register file and bus state.
    logic mode_direct_q;
    logic awready_q;
    logic wready_q;
    logic aw_got_q;
    logic w_got_q;
    logic [pstep_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire logic [NI-1:0] raw_in = {PITCH_CENTER_PULSE, PITCH_LOWER_PULSE,
                                   PITCH_RAISE_PULSE, STEP_SEL};
    wire logic [NI-1:0] rise = clean_q & ~clean_prev_q;
    wire logic raise_rise = rise[pstep_pkg::IDX_RAISE];
    wire logic lower_rise = rise[pstep_pkg::IDX_LOWER];
    wire logic raise_lvl = clean_q[pstep_pkg::IDX_RAISE];
    wire logic lower_lvl = clean_q[pstep_pkg::IDX_LOWER];
    // A raise arriving while lower is already held counts as both together.
    wire logic center_hit = rise[pstep_pkg::IDX_CENTER]
                          | (raise_rise & lower_lvl)
                          | (lower_rise & raise_lvl);
    wire logic [7:0] cur_us = pstep_pkg::period_us(step_q);
    wire logic [pstep_pkg::PERIOD_W-1:0] per_last =
        pstep_pkg::PERIOD_W'(int'(cur_us) * pstep_pkg::TICKS_PER_US - 1);
    wire logic per_wrap = per_cnt_q >= per_last;

    // Step selection.
    always_comb begin
        step_d = step_q;
        if (mode_direct_q) begin
            step_d = {1'b0, clean_q[3:0]};
        end else if (center_hit) begin
            step_d = pstep_pkg::STEP_CENTER;
        end else if (raise_rise && step_q != pstep_pkg::STEP_MAX) begin
            step_d = step_q + 5'h01;
        end else if (lower_rise && step_q != pstep_pkg::STEP_MIN) begin
            step_d = step_q - 5'h01;
        end
    end

    // Master tick at 4 MHz.
    always_ff @(posedge CLK) begin
        if (SYS_RST || div_q == DIV_LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
        tick_q <= !SYS_RST && div_q == DIV_LAST;
    end

    // Two-stage synchroniser; only the second stage feeds the filters.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // Chatter filter: a level must differ from the accepted one for the whole
    // debounce time before it is taken; any bounce back restarts the count.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            clean_q <= '0;
            clean_prev_q <= '0;
            for (int i = 0; i < NI; i++) begin
                deb_cnt_q[i] <= '0;
            end
        end else begin
            clean_prev_q <= clean_q;
            for (int i = 0; i < NI; i++) begin
                if (sync2_q[i] == clean_q[i]) begin
                    deb_cnt_q[i] <= '0;
                end else if (tick_q && deb_cnt_q[i] == DEB_LAST) begin
                    deb_cnt_q[i] <= '0;
                    clean_q[i] <= sync2_q[i];
                end else if (tick_q) begin
                    deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // Step register and sampling strobe. The period counter compares with
    // greater-or-equal so a step change to a shorter period never overruns.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            step_q <= pstep_pkg::STEP_RESET;
            per_cnt_q <= '0;
            strobe_q <= 1'b0;
        end else begin
            step_q <= step_d;
            strobe_q <= tick_q && per_wrap;
            if (tick_q) begin
                per_cnt_q <= per_wrap ? '0 : per_cnt_q + 1'b1;
            end
        end
    end

    // Word compare; the two low address bits are ignored, so any byte address
    // inside a register reaches the whole register.
    function automatic logic hits(input logic [pstep_pkg::ADDR_W-1:0] addr,
                                  input logic [pstep_pkg::ADDR_W-1:0] base);
        hits = addr[pstep_pkg::ADDR_W-1:2] == base[pstep_pkg::ADDR_W-1:2];
    endfunction

    function automatic logic mapped(input logic [pstep_pkg::ADDR_W-1:0] addr);
        mapped = hits(addr, pstep_pkg::ADDR_CTRL)
               || hits(addr, pstep_pkg::ADDR_STATUS)
               || hits(addr, pstep_pkg::ADDR_PERIOD);
    endfunction

    // Register decode.
    wire logic wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire logic wr_ctrl = hits(awaddr_q, pstep_pkg::ADDR_CTRL);
    wire logic wr_known = mapped(awaddr_q);
    wire logic aw_take = S_AXI_AWVALID && awready_q;
    wire logic w_take = S_AXI_WVALID && wready_q;
    wire logic b_done = bvalid_q && S_AXI_BREADY;
    wire logic ar_fire = S_AXI_ARVALID && arready_q;
    wire logic rd_ctrl = hits(S_AXI_ARADDR, pstep_pkg::ADDR_CTRL);
    wire logic rd_stat = hits(S_AXI_ARADDR, pstep_pkg::ADDR_STATUS);
    wire logic rd_per = hits(S_AXI_ARADDR, pstep_pkg::ADDR_PERIOD);
    wire logic rd_known = mapped(S_AXI_ARADDR);
    wire logic [31:0] ctrl_word = {31'h0, mode_direct_q};
    wire logic [31:0] stat_word = {17'h0, clean_q, 3'h0, step_q};
    wire logic [31:0] per_word = {24'h0, cur_us};
    wire logic [31:0] rd_word = rd_ctrl ? ctrl_word
                              : rd_stat ? stat_word
                              : rd_per ? per_word : 32'h0;

    // Write address channel: the ready stays low until the response is taken,
    // so a take and a release can never fall in the same cycle.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            awready_q <= 1'b1;
            aw_got_q <= 1'b0;
            awaddr_q <= '0;
        end else if (aw_take) begin
            awaddr_q <= S_AXI_AWADDR;
            aw_got_q <= 1'b1;
            awready_q <= 1'b0;
        end else if (b_done) begin
            aw_got_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    // Write data channel: taken in either order relative to the address.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wready_q <= 1'b1;
            w_got_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (w_take) begin
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
            w_got_q <= 1'b1;
            wready_q <= 1'b0;
        end else if (b_done) begin
            w_got_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    // Response and control register: the write lands once both halves are in.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bvalid_q <= 1'b0;
            bresp_q <= pstep_pkg::RESP_OKAY;
            mode_direct_q <= pstep_pkg::CTRL_MODE_RESET;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? pstep_pkg::RESP_OKAY : pstep_pkg::RESP_SLVERR;
            if (wr_ctrl && wstrb_q[0]) begin
                mode_direct_q <= wdata_q[pstep_pkg::CTRL_MODE_BIT];
            end
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel: one read at a time. The address is decoded straight from
    // the bus pins, so it must stand with its valid at the taking edge.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= pstep_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_known ? pstep_pkg::RESP_OKAY : pstep_pkg::RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign PITCH_STEP = step_q;
    assign DA_SAMPLE_STROBE = strobe_q;
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

endmodule

// ===== pstep_pkg.sv
/*
 * Shared constants for the pitch step controller: clock rates, debounce
 * timing, step limits, register offsets and the sampling period table.
 * Assumes a 200 MHz system clock from which a 4 MHz master tick is divided.
 */
package pstep_pkg;

    // Clock rates and the divider that makes the 4 MHz master tick.
    localparam int CLK_KHZ = 200000;
    localparam int MASTER_KHZ = 4000;
    localparam int TICK_DIV = CLK_KHZ / MASTER_KHZ;
    localparam int TICK_DIV_W = 6;
    localparam int TICKS_PER_US = MASTER_KHZ / 1000;

    // Chatter suppression time and its length in master ticks.
    localparam int DEBOUNCE_MS = 62;
    localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * MASTER_KHZ;
    localparam int DEBOUNCE_W = 18;

    // Number of filtered inputs: four select lines, raise, lower, centre.
    localparam int NUM_INPUTS = 7;
    localparam int IDX_RAISE = 4;
    localparam int IDX_LOWER = 5;
    localparam int IDX_CENTER = 6;

    // Pitch step range and the value after reset.
    localparam logic [4:0] STEP_MIN = 5'h00;
    localparam logic [4:0] STEP_CENTER = 5'h08;
    localparam logic [4:0] STEP_MAX = 5'h10;
    localparam logic [4:0] STEP_RESET = STEP_CENTER;

    // Sampling period counter width in master ticks (908 ticks at most).
    localparam int PERIOD_W = 10;

    // Register map, byte addresses on the 32-bit register bus.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam int CTRL_MODE_BIT = 0;
    localparam logic CTRL_MODE_RESET = 1'b0;
    localparam int STATUS_INPUTS_LSB = 8;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // DA sampling period in microseconds for each pitch step.
    function automatic logic [7:0] period_us(input logic [4:0] step);
        case (step)
            5'h00: period_us = 8'd227;
            5'h01: period_us = 8'd202;
            5'h02: period_us = 8'd190;
            5'h03: period_us = 8'd180;
            5'h04: period_us = 8'd160;
            5'h05: period_us = 8'd151;
            5'h06: period_us = 8'd143;
            5'h07: period_us = 8'd127;
            5'h08: period_us = 8'd120;
            5'h09: period_us = 8'd113;
            5'h0a: period_us = 8'd101;
            5'h0b: period_us = 8'd90;
            5'h0c: period_us = 8'd90;
            5'h0d: period_us = 8'd80;
            5'h0e: period_us = 8'd76;
            5'h0f: period_us = 8'd71;
            default: period_us = 8'd60;
        endcase
    endfunction

endpackage

// ===== pstep_ctrl_chk.sv
/* Port-level assertions for the pitch step controller.
   Assumes it is bound to the controller with the same debounce count. */
module pstep_chk #(
    parameter int DEBOUNCE_TICKS = 4
) (
    // Clock, reset and pitch pins.
    input wire logic CLK, SYS_RST,
    input wire logic [3:0] STEP_SEL,
    input wire logic PITCH_RAISE_PULSE, PITCH_LOWER_PULSE, PITCH_CENTER_PULSE,
    // Converter side.
    input wire logic [4:0] PITCH_STEP,
    input wire logic DA_SAMPLE_STROBE,
    // Register bus.
    input wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input wire logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
    input wire logic S_AXI_RVALID, S_AXI_RREADY,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic [pstep_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [31:0] S_AXI_RDATA
);
    timeunit 1ns;
    timeprecision 100ps;
    // Sync stages, tick phase and the step register all fit inside this margin.
    localparam int SETTLE = (DEBOUNCE_TICKS + 2) * pstep_pkg::TICK_DIV;
    localparam int CLK_PER_US = pstep_pkg::TICK_DIV * pstep_pkg::TICKS_PER_US;
    logic [7:0] per_us [17] = '{8'he3, 8'hca, 8'hbe, 8'hb4, 8'ha0, 8'h97, 8'h8f, 8'h7f, 8'h78,
        8'h71, 8'h65, 8'h5a, 8'h5a, 8'h50, 8'h4c, 8'h47, 8'h3c};
    logic pins_low;
    logic steady_q;
    int quiet_q;
    int gap_q;
    assign pins_low = STEP_SEL == 4'h0 && !PITCH_RAISE_PULSE && !PITCH_LOWER_PULSE
        && !PITCH_CENTER_PULSE;
    // An interval is only judged when the step held still since the strobe that opened it.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            quiet_q <= 0;
            gap_q <= 0;
            steady_q <= 1'b0;
        end else begin
            quiet_q <= !pins_low ? 0 : (quiet_q > SETTLE ? quiet_q : quiet_q + 1);
            gap_q <= DA_SAMPLE_STROBE ? 1 : gap_q + 1;
            steady_q <= DA_SAMPLE_STROBE || (steady_q && !$changed(PITCH_STEP));
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_quiet_hold;
        quiet_q > SETTLE && !S_AXI_BVALID && !$past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2)
            |-> $stable(PITCH_STEP);
    endproperty
    a_quiet_hold: assert property (p_quiet_hold)
        else $error("Step moved while the pins were idle");
    property p_strobe_single;
        DA_SAMPLE_STROBE |=> !DA_SAMPLE_STROBE;
    endproperty
    a_strobe_single: assert property (p_strobe_single)
        else $error("Sampling strobe longer than one cycle");
    property p_strobe_gap;
        DA_SAMPLE_STROBE && steady_q && $stable(PITCH_STEP)
            |-> gap_q == int'(per_us[PITCH_STEP]) * CLK_PER_US;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("Sampling period does not match the step");
    property p_reset_state;
        disable iff (1'b0) SYS_RST |=> PITCH_STEP == pstep_pkg::STEP_RESET
            && !DA_SAMPLE_STROBE && !S_AXI_BVALID && !S_AXI_RVALID;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("Wrong state after reset");
    property p_step_range;
        PITCH_STEP <= pstep_pkg::STEP_MAX;
    endproperty
    a_step_range: assert property (p_step_range)
        else $error("Step beyond the top step");
    // Both halves are registered first, so the response rises one cycle after the readies fall.
    property p_write_answer;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("Write response missing");
    property p_write_release;
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY;
    endproperty
    a_write_release: assert property (p_write_release)
        else $error("Write channel not released");
    property p_read_answer;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("Read response missing");
    property p_unmapped;
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] > 6'h02
            |=> S_AXI_RRESP == pstep_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not refused");
    c_gap: cover property (DA_SAMPLE_STROBE && steady_q && $stable(PITCH_STEP));
    c_top: cover property (PITCH_STEP == pstep_pkg::STEP_MAX);
    c_unmapped: cover property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] > 6'h02);
endmodule

// ===== pstep_buttons.sv
/* Push-button model for the seven pitch pins.
   Assumes its task is called just after a rising clock edge. */
module pstep_buttons (
    // Clock and pins.
    input wire logic clk,
    output logic [6:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins = 7'h00;
    // Each call drives the whole mask, so released pins go low, never keeping the old level.
    task automatic drive(input logic [6:0] m, input int n);
        pins <= m;
        repeat (n) @(posedge clk);
    endtask
endmodule

// ===== pitch_step_controller_bench.sv
/* Self-checking bench for the pitch step controller.
   Assumes the package, the button model and the checker are compiled first. */
module pitch_step_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [6:0] m; logic [8:0] hold; logic [4:0] step; logic [7:0] per;} pstep_row_t;
    // Raise, lower, lower, centre, raise, both together, then a pulse too short to count.
    pstep_row_t rows [7] = '{'{7'h10, 9'h190, 5'h09, 8'h71}, '{7'h20, 9'h190, 5'h08, 8'h78},
        '{7'h20, 9'h190, 5'h07, 8'h7f}, '{7'h40, 9'h190, 5'h08, 8'h78},
        '{7'h10, 9'h190, 5'h09, 8'h71}, '{7'h30, 9'h190, 5'h08, 8'h78},
        '{7'h10, 9'h078, 5'h08, 8'h78}};
    logic [3:0] sel [3] = '{4'ha, 4'hf, 4'h0};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [6:0] pins;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, strobe, aw, w;
    logic [1:0] bresp, rresp, rs;
    logic [4:0] step;
    int num_errors = 0, n_tests = 0, cycles = 0;
    always #2.5 clk = ~clk;
    pstep_buttons btn (.clk(clk), .pins(pins));
    pstep_ctrl #(.DEBOUNCE_TICKS(4)) dut (.CLK(clk), .SYS_RST(sys_rst), .STEP_SEL(pins[3:0]),
        .PITCH_RAISE_PULSE(pins[4]), .PITCH_LOWER_PULSE(pins[5]), .PITCH_CENTER_PULSE(pins[6]),
        .PITCH_STEP(step), .DA_SAMPLE_STROBE(strobe), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            aw = aw && !awready;
            w = w && !wready;
        end while (aw || w);
        do @(posedge clk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [6:0] m, input int h);
        btn.drive(m, h);
        btn.drive(7'h00, 400);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // The planned sequence needs about 41000 cycles, so this leaves ample slack.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("reset step", 32'(step), 32'h8);
        rd_reg(pstep_pkg::ADDR_CTRL);
        check("ctrl reset", rd, 32'h0);
        rd_reg(8'h0c);
        check("unmapped read", 32'(rs), 32'(pstep_pkg::RESP_SLVERR));
        wr(8'h0c, 32'h1);
        check("unmapped write", 32'(rs), 32'(pstep_pkg::RESP_SLVERR));
        wr(pstep_pkg::ADDR_PERIOD, 32'h1);
        check("read-only write", 32'(rs), 32'(pstep_pkg::RESP_OKAY));
        foreach (rows[i]) begin
            pulse(rows[i].m, int'(rows[i].hold));
            check("row step", 32'(step), 32'(rows[i].step));
            rd_reg(pstep_pkg::ADDR_PERIOD);
            check("row period", 32'(rd[7:0]), 32'(rows[i].per));
        end
        repeat (8) pulse(7'h10, 400);
        check("top step", 32'(step), 32'h10);
        pulse(7'h10, 400);
        check("saturate high", 32'(step), 32'h10);
        rd_reg(pstep_pkg::ADDR_PERIOD);
        check("top period", 32'(rd[7:0]), 32'h3c);
        rd_reg(pstep_pkg::ADDR_STATUS);
        check("status word", rd, 32'(pstep_pkg::STEP_MAX));
        repeat (25000) @(posedge clk);
        wr(pstep_pkg::ADDR_CTRL, 32'h1);
        rd_reg(pstep_pkg::ADDR_CTRL);
        check("ctrl direct", rd, 32'h1);
        foreach (sel[i]) begin
            btn.drive({3'h0, sel[i]}, 400);
            check("direct step", 32'(step), 32'(sel[i]));
        end
        pulse(7'h10, 400);
        check("direct ignores raise", 32'(step), 32'h0);
        wr(pstep_pkg::ADDR_CTRL, 32'h0);
        pulse(7'h20, 400);
        check("saturate low", 32'(step), 32'h0);
        pulse(7'h10, 400);
        check("raise from zero", 32'(step), 32'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("second reset", 32'(step), 32'h8);
        end_of_test();
    end
endmodule
bind pstep_ctrl pstep_chk #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS)) chk (.CLK(CLK), .SYS_RST(SYS_RST),
    .STEP_SEL(STEP_SEL), .PITCH_RAISE_PULSE(PITCH_RAISE_PULSE),
    .PITCH_LOWER_PULSE(PITCH_LOWER_PULSE), .PITCH_CENTER_PULSE(PITCH_CENTER_PULSE),
    .PITCH_STEP(PITCH_STEP), .DA_SAMPLE_STROBE(DA_SAMPLE_STROBE),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_RDATA(S_AXI_RDATA));
